// >>> verilog/alu_slice_pkg.sv
// Shared constants, types and register map of the cascadable four-bit ALU slice
`default_nettype none
package alu_slice_pkg;
  // ----------------------------------------------------------------
  // Register map (APB byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] PEEK_ADDR_OFS = 8'h04;
  localparam logic [7:0] PEEK_DATA_OFS = 8'h08;
  localparam logic [3:0] PEEK_ADDR_RST = 4'h0;
  localparam logic [3:0] Q_RST = 4'h0;
  localparam logic SIGN_RST = 1'b0;
  localparam logic [31:0] PRDATA_RST = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Special function codes on the destination field
  // ----------------------------------------------------------------
  localparam logic [3:0] SF_UMUL = 4'h0;
  localparam logic [3:0] SF_TMUL = 4'h2;
  localparam logic [3:0] SF_INC = 4'h4;
  localparam logic [3:0] SF_SMAG = 4'h5;
  localparam logic [3:0] SF_TMUL_LAST = 4'h6;
  localparam logic [3:0] SF_NORM1 = 4'h8;
  localparam logic [3:0] SF_NORM2 = 4'ha;
  localparam logic [3:0] SF_DIV = 4'hc;
  localparam logic [3:0] SF_DIV_LAST = 4'he;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {POS_LOW, POS_MID, POS_TOP} slice_pos_e;
  typedef struct packed {
    logic o;
    logic oe;
  } pad_s;
  typedef struct packed {
    logic [3:0] q;
    logic sign;
    logic is_low;
    logic is_top;
  } slice_status_s;
endpackage
`default_nettype wire

// >>> verilog/alu_slice.sv
// Four-bit cascadable ALU slice: RAM, operand select, ALU, shifters, status pins, APB peek port
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module alu_slice
  import alu_slice_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] ram_a_addr,
  input wire logic [3:0] ram_b_addr,
  input wire logic [8:0] instr,
  input wire logic instr_gate_n,
  input wire logic carry_in,
  input wire logic r_source_sel,
  input wire logic [3:0] ext_r_operand_in,
  input wire logic b_drive_n,
  input wire logic y_drive_n,
  input wire logic ram_we_n,
  input wire logic bottom_slice_strap,
  input wire logic [3:0] b_port_bus_in,
  output logic [3:0] b_port_bus_out,
  output logic b_port_bus_oe,
  input wire logic [3:0] y_in,
  output logic [3:0] y_out,
  output logic y_oe,
  input wire logic alu_shift_low_in,
  output pad_s alu_shift_low,
  input wire logic alu_shift_high_in,
  output pad_s alu_shift_high,
  input wire logic q_shift_low_port_in,
  output pad_s q_shift_low_port,
  input wire logic q_shift_high_port_in,
  output pad_s q_shift_high_port,
  input wire logic write_or_top_strap_in,
  output pad_s write_or_top_strap,
  input wire logic zero_in,
  output pad_s zero_line,
  output logic carry_out,
  output logic gen_or_sign,
  output logic propagate_or_overflow
);
  // ----------------------------------------------------------------
  // Adder: returns {carry into bit 3, carry out, sum}
  // ----------------------------------------------------------------
  function automatic logic [5:0] add4(input logic [3:0] a, input logic [3:0] b, input logic cin);
    logic [3:0] lo;
    logic [4:0] s;
    lo = {1'b0, a[2:0]} + {1'b0, b[2:0]} + {3'b000, cin};
    s = {1'b0, a} + {1'b0, b} + {4'h0, cin};
    return {lo[3], s};
  endfunction

  logic [3:0] ram_mem [16];
  logic [3:0] ram_a_word, ram_b_word;
  logic [3:0] q_q, q_d, peek_q;
  logic sign_q, sign_d, q_ld, sign_ld;
  logic [31:0] rd_q;
  logic err_q;
  slice_pos_e pos;
  logic is_low, is_top, special;
  logic [3:0] dest, op;
  logic [3:0] r_op, s_op, a_in, b_in, f, y_val, g, p;
  logic [5:0] sum;
  logic c3, c4, ovr, arith, gg, pp, parity, ram_store, z_drv, z_val;

  // ----------------------------------------------------------------
  // RAM and slice position
  // ----------------------------------------------------------------
  assign ram_a_word = ram_mem[ram_a_addr];
  assign ram_b_word = ram_mem[ram_b_addr];

  // The bus level is stored, so external data on a floated result bus lands in RAM.
  // The write is taken at the rising edge that closes the low clock phase.
  always_ff @(posedge pclk) begin
    if (!ram_we_n) begin
      ram_mem[ram_b_addr] <= y_in;
    end
  end

  always_comb begin
    if (!bottom_slice_strap) begin
      pos = POS_LOW;
    end else if (write_or_top_strap_in) begin
      pos = POS_MID;
    end else begin
      pos = POS_TOP;
    end
  end
  assign is_low = (pos == POS_LOW);
  assign is_top = (pos == POS_TOP);

  // ----------------------------------------------------------------
  // Decode and ALU
  // ----------------------------------------------------------------
  assign special = (instr[4:0] == 5'h00);
  assign dest = instr[8:5];
  assign op = instr[4:1];
  assign r_op = r_source_sel ? ext_r_operand_in : ram_a_word;
  assign s_op = instr[0] ? b_port_bus_in : ram_b_word;

  always_comb begin
    a_in = r_op;
    b_in = s_op;
    arith = 1'b1;
    f = 4'h0;
    if (special) begin
      case (dest)
        SF_UMUL, SF_TMUL: a_in = zero_in ? r_op : 4'h0;
        SF_INC: a_in = {3'b000, is_low};
        SF_SMAG: begin
          a_in = 4'h0;
          b_in = zero_in ? ~s_op : s_op;
        end
        SF_TMUL_LAST: a_in = zero_in ? ~r_op : 4'h0;
        SF_DIV, SF_DIV_LAST: a_in = zero_in ? ~r_op : r_op;
        default: a_in = 4'h0;
      endcase
    end else begin
      case (op)
        4'h1: a_in = ~r_op;
        4'h2: b_in = ~s_op;
        4'h3: a_in = r_op;
        4'h4: a_in = 4'h0;
        4'h5: begin
          a_in = 4'h0;
          b_in = ~s_op;
        end
        4'h6: b_in = 4'h0;
        4'h7: begin
          a_in = ~r_op;
          b_in = 4'h0;
        end
        default: arith = 1'b0;
      endcase
      case (op)
        4'h0: f = 4'hf;
        4'h9: f = ~r_op & s_op;
        4'ha: f = ~(r_op ^ s_op);
        4'hb: f = r_op ^ s_op;
        4'hc: f = r_op & s_op;
        4'hd: f = ~(r_op | s_op);
        4'he: f = ~(r_op & s_op);
        4'hf: f = r_op | s_op;
        default: f = 4'h0;
      endcase
    end
  end

  assign sum = add4(a_in, b_in, carry_in);
  assign c3 = arith & sum[5];
  assign c4 = arith & sum[4];
  assign ovr = c3 ^ c4;
  assign g = arith ? (a_in & b_in) : 4'h0;
  assign p = arith ? (a_in | b_in) : 4'hf;
  assign gg = g[3] | (g[2] & p[3]) | (g[1] & p[2] & p[3]) | (g[0] & p[1] & p[2] & p[3]);
  assign pp = &p;
  logic [3:0] f_res;
  assign f_res = arith ? sum[3:0] : f;
  assign parity = alu_shift_high_in ^ (^f_res);

  // ----------------------------------------------------------------
  // Shifters, write strobe and shift port directions
  // ----------------------------------------------------------------
  always_comb begin
    y_val = f_res;
    q_d = q_q;
    q_ld = 1'b0;
    sign_d = ~(r_op[3] ^ f_res[3]);
    sign_ld = 1'b0;
    ram_store = 1'b1;
    alu_shift_low = '0;
    alu_shift_high = '0;
    q_shift_low_port = '0;
    q_shift_high_port = '0;
    if (special) begin
      case (dest)
        SF_UMUL, SF_TMUL, SF_TMUL_LAST: begin
          if (is_top) begin
            y_val = {(dest == SF_UMUL) ? c4 : (f_res[3] ^ ovr), f_res[3:1]};
          end else begin
            y_val = {alu_shift_high_in, f_res[3:1]};
          end
          alu_shift_low = '{o: f_res[0], oe: 1'b1};
          q_d = {q_shift_high_port_in, q_q[3:1]};
          q_ld = 1'b1;
          q_shift_low_port = '{o: q_q[0], oe: 1'b1};
        end
        SF_INC, SF_SMAG: begin
          if (dest == SF_SMAG && is_top) begin
            y_val[3] = s_op[3] ^ f_res[3];
          end
          alu_shift_low = '{o: parity, oe: 1'b1};
        end
        SF_NORM1, SF_NORM2, SF_DIV, SF_DIV_LAST: begin
          if (dest == SF_NORM2 || dest == SF_DIV) begin
            y_val = {f_res[2:0], alu_shift_low_in};
          end
          alu_shift_high.oe = 1'b1;
          alu_shift_high.o = f_res[3];
          if (is_top && dest == SF_NORM2) begin
            alu_shift_high.o = r_op[3] ^ f_res[3];
          end else if (is_top && dest == SF_DIV) begin
            alu_shift_high.o = ~(r_op[3] ^ f_res[3]);
          end
          q_d = {q_q[2:0], q_shift_low_port_in};
          q_ld = 1'b1;
          q_shift_high_port = '{o: q_q[3], oe: 1'b1};
          sign_ld = (dest != SF_NORM1);
        end
        default: ram_store = 1'b0;
      endcase
    end else begin
      ram_store = (dest != 4'hc) && (dest != 4'hd);
      case (dest)
        4'h0, 4'h1, 4'h2, 4'h3: begin
          y_val = {(is_top && dest[0] == 1'b0) ? f_res[3] : alu_shift_high_in, f_res[3:1]};
          alu_shift_low = '{o: f_res[0], oe: 1'b1};
          if (dest[1]) begin
            q_d = {q_shift_high_port_in, q_q[3:1]};
            q_ld = 1'b1;
            q_shift_low_port = '{o: q_q[0], oe: 1'b1};
          end
        end
        4'h4, 4'h5, 4'h6, 4'h7: begin
          alu_shift_low = '{o: parity, oe: 1'b1};
          if (dest == 4'h5) begin
            q_d = {q_shift_high_port_in, q_q[3:1]};
            q_shift_low_port = '{o: q_q[0], oe: 1'b1};
          end else if (dest[1]) begin
            q_d = f_res;
          end
          q_ld = (dest != 4'h4);
        end
        4'h8, 4'h9, 4'ha, 4'hb, 4'hd: begin
          if (dest != 4'hd) begin
            y_val = {f_res[2:0], alu_shift_low_in};
          end
          alu_shift_high = '{o: f_res[3], oe: 1'b1};
          if (dest[1] || dest == 4'hd) begin
            q_d = {q_q[2:0], q_shift_low_port_in};
            q_ld = 1'b1;
            q_shift_high_port = '{o: q_q[3], oe: 1'b1};
          end
        end
        4'he: begin
          y_val = {4{alu_shift_low_in}};
          alu_shift_high = '{o: alu_shift_low_in, oe: 1'b1};
        end
        default: alu_shift_high = '{o: f_res[3], oe: 1'b1};
      endcase
    end
  end

  // Q register and sign compare flip-flop; the gate freezes both
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_q <= Q_RST;
    end else if (!instr_gate_n && q_ld) begin
      q_q <= q_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sign_q <= SIGN_RST;
    end else if (!instr_gate_n && sign_ld) begin
      sign_q <= sign_d;
    end
  end

  // ----------------------------------------------------------------
  // Pins: buses, write strobe, status
  // ----------------------------------------------------------------
  assign b_port_bus_out = ram_b_word;
  assign b_port_bus_oe = !b_drive_n;
  assign y_out = y_val;
  assign y_oe = !y_drive_n;
  // Only the lowest slice owns the shared pin; elsewhere it is a strap input.
  assign write_or_top_strap.o = instr_gate_n | ~ram_store;
  assign write_or_top_strap.oe = is_low;

  always_comb begin
    z_drv = 1'b1;
    z_val = ~|y_in;
    if (special) begin
      case (dest)
        SF_UMUL, SF_TMUL, SF_TMUL_LAST: begin
          z_drv = is_low;
          z_val = q_q[0];
        end
        SF_SMAG: begin
          z_drv = is_top;
          z_val = s_op[3];
        end
        SF_NORM1: z_val = ~|q_q;
        SF_NORM2: z_val = ~|{q_q, f_res};
        SF_DIV, SF_DIV_LAST: begin
          z_drv = is_top;
          z_val = sign_q;
        end
        default: z_drv = 1'b1;
      endcase
    end
  end
  // Open collector: only ever pulls low, the wire floats high otherwise
  assign zero_line.o = 1'b0;
  assign zero_line.oe = z_drv & ~z_val;

  always_comb begin
    carry_out = c4;
    if (special && is_top && dest == SF_NORM1) begin
      carry_out = q_q[3] ^ q_q[2];
    end else if (special && is_top && dest == SF_NORM2) begin
      carry_out = f_res[3] ^ f_res[2];
    end
  end

  always_comb begin
    gen_or_sign = ~gg;
    propagate_or_overflow = ~pp;
    if (is_top) begin
      gen_or_sign = f_res[3];
      propagate_or_overflow = ovr;
      if (special && dest == SF_SMAG && zero_in) begin
        gen_or_sign = f_res[3] ^ s_op[3];
      end else if (special && dest == SF_NORM1) begin
        gen_or_sign = q_q[3];
        propagate_or_overflow = q_q[2] ^ q_q[1];
      end else if (special && dest == SF_NORM2) begin
        propagate_or_overflow = f_res[2] ^ f_res[1];
      end
    end
  end

  // ----------------------------------------------------------------
  // APB slave: zero wait states, read data captured in the setup cycle
  // ----------------------------------------------------------------
  slice_status_s status;
  assign status = '{q: q_q, sign: sign_q, is_low: is_low, is_top: is_top};
  assign pready = 1'b1;
  assign prdata = rd_q;
  assign pslverr = psel & penable & err_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= PRDATA_RST;
      err_q <= 1'b0;
    end else if (psel && !penable) begin
      err_q <= 1'b0;
      rd_q <= PRDATA_RST;
      case (paddr)
        STATUS_OFS: rd_q <= {25'h0, status};
        PEEK_ADDR_OFS: rd_q <= {28'h0, peek_q};
        PEEK_DATA_OFS: rd_q <= {28'h0, ram_mem[peek_q]};
        default: err_q <= 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peek_q <= PEEK_ADDR_RST;
    end else if (psel && penable && pwrite && paddr == PEEK_ADDR_OFS) begin
      peek_q <= pwdata[3:0];
    end
  end

  // Words written since reset; the RAM checks skip unwritten words, which hold no defined value
  logic [15:0] ram_seen_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_seen_q <= 16'h0000;
    end else if (!ram_we_n) begin
      ram_seen_q[ram_b_addr] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence gated_step;
    !instr_gate_n && special;
  endsequence
  sequence mul_step;
    gated_step ##0 (dest == SF_UMUL);
  endsequence

  a_gate_write_high: assert property (instr_gate_n |-> write_or_top_strap.o)
    else $error("write strobe low while gated");
  a_gate_q_hold: assert property (instr_gate_n |=> $stable(q_q) && $stable(sign_q))
    else $error("Q or sign changed while gated");
  a_write_strobe_low: assert property (is_low && !instr_gate_n && ram_store |-> write_or_top_strap.oe && !write_or_top_strap.o)
    else $error("write strobe not low for storing instruction");
  a_strap_buf_off: assert property (bottom_slice_strap |-> !write_or_top_strap.oe)
    else $error("write buffer on at upper slice");
  a_ram_store: assert property (!ram_we_n |=> ram_mem[$past(ram_b_addr)] == $past(y_in))
    else $error("RAM missed write");
  a_ram_hold: assert property (ram_we_n && ram_seen_q[ram_a_addr] |=> ram_mem[$past(ram_a_addr)] == $past(ram_a_word))
    else $error("RAM changed without enable");
  a_b_bus_drive: assert property (b_port_bus_oe == !b_drive_n && (!ram_seen_q[ram_b_addr] || b_port_bus_out == ram_mem[ram_b_addr]))
    else $error("B bus drive wrong");
  a_mul_q_shift: assert property (mul_step |=> q_q == {$past(q_shift_high_port_in), $past(q_q[3:1])})
    else $error("multiply Q shift wrong");
  a_norm_carry: assert property (special && is_top && dest == SF_NORM1 |-> carry_out == (q_q[3] ^ q_q[2]))
    else $error("normalize carry wrong");
  a_div_zero_line: assert property (special && is_top && dest == SF_DIV |-> zero_line.oe == !sign_q)
    else $error("sign flip-flop not on zero line");
  a_zero_detect: assert property (!special && y_in != 4'h0 |-> zero_line.oe)
    else $error("zero line not pulled low");
endmodule
`default_nettype wire

// >>> verification/slice_neighbours.sv
// Far-side model: system straps, neighbour slices and the pulled-up zero wire
`timescale 1ns/10ps
`default_nettype none
module slice_neighbours
  import alu_slice_pkg::*;
(
  input wire logic [3:0] y_out,
  input wire logic y_oe,
  input wire logic [3:0] y_far,
  input wire logic [3:0] b_port_bus_out,
  input wire logic b_port_bus_oe,
  input wire logic [3:0] b_far,
  input wire pad_s alu_shift_low,
  input wire pad_s alu_shift_high,
  input wire pad_s q_shift_low_port,
  input wire pad_s q_shift_high_port,
  input wire logic [3:0] shift_far,
  input wire pad_s write_or_top_strap,
  input wire logic strap_far,
  input wire pad_s zero_line,
  output logic [3:0] y_in,
  output logic [3:0] b_port_bus_in,
  output logic alu_shift_low_in,
  output logic alu_shift_high_in,
  output logic q_shift_low_port_in,
  output logic q_shift_high_port_in,
  output logic write_or_top_strap_in,
  output logic zero_in
);
  // Neighbours drive every shift line that this slice leaves free
  assign alu_shift_low_in = alu_shift_low.oe ? alu_shift_low.o : shift_far[0];
  assign alu_shift_high_in = alu_shift_high.oe ? alu_shift_high.o : shift_far[1];
  assign q_shift_low_port_in = q_shift_low_port.oe ? q_shift_low_port.o : shift_far[2];
  assign q_shift_high_port_in = q_shift_high_port.oe ? q_shift_high_port.o : shift_far[3];
  assign y_in = y_oe ? y_out : y_far;
  assign b_port_bus_in = b_port_bus_oe ? b_port_bus_out : b_far;
  // Shared pin: tie level only where the slice leaves its write buffer off
  assign write_or_top_strap_in = write_or_top_strap.oe ? write_or_top_strap.o : strap_far;
  // Open-drain wire with pull-up
  assign zero_in = !(zero_line.oe && !zero_line.o);
endmodule
`default_nettype wire

// >>> verification/tb_alu_slice.sv
// Self-checking bench for the four-bit ALU slice
`timescale 1ns/10ps
`default_nettype none
module tb_alu_slice
  import alu_slice_pkg::*;
  ;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, instr_gate_n, carry_in, r_source_sel, b_drive_n;
  logic y_drive_n, ram_we_n, bottom_slice_strap, b_port_bus_oe, y_oe, alu_shift_low_in, alu_shift_high_in;
  logic q_shift_low_port_in, q_shift_high_port_in, write_or_top_strap_in, zero_in, carry_out, gen_or_sign;
  logic propagate_or_overflow, strap_far, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed, rd;
  logic [8:0] instr;
  logic [3:0] ram_a_addr, ram_b_addr, ext_r_operand_in, b_port_bus_in, b_port_bus_out, y_in, y_out;
  logic [3:0] y_far, b_far, shift_far, f;
  pad_s alu_shift_low, alu_shift_high, q_shift_low_port, q_shift_high_port, write_or_top_strap, zero_line;
  int bad_count, samples_checked, q_m, k;
  int ram_m [16];
  logic [3:0] sf_list [9];

  slice_neighbours far_side (.y_out, .y_oe, .y_far, .b_port_bus_out, .b_port_bus_oe, .b_far, .alu_shift_low,
    .alu_shift_high, .q_shift_low_port, .q_shift_high_port, .shift_far, .write_or_top_strap, .strap_far,
    .zero_line, .y_in, .b_port_bus_in, .alu_shift_low_in, .alu_shift_high_in, .q_shift_low_port_in,
    .q_shift_high_port_in, .write_or_top_strap_in, .zero_in);
  alu_slice DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ram_a_addr, .ram_b_addr, .instr, .instr_gate_n, .carry_in, .r_source_sel, .ext_r_operand_in, .b_drive_n,
    .y_drive_n, .ram_we_n, .bottom_slice_strap, .b_port_bus_in, .b_port_bus_out, .b_port_bus_oe, .y_in, .y_out,
    .y_oe, .alu_shift_low_in, .alu_shift_low, .alu_shift_high_in, .alu_shift_high, .q_shift_low_port_in,
    .q_shift_low_port, .q_shift_high_port_in, .q_shift_high_port, .write_or_top_strap_in, .write_or_top_strap,
    .zero_in, .zero_line, .carry_out, .gen_or_sign, .propagate_or_overflow);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[3:0];
  endfunction

  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait until pready is high; the watchdog ends a wait that never sees it
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Control word c is {ram_we_n, y_drive_n, b_drive_n}; outputs are looked at 1 ns after the edge
  task automatic go(input logic [8:0] i, input logic g, input logic rs, input logic [7:0] ab,
                    input logic [3:0] e, input logic [3:0] bf, input logic [2:0] c);
    @(posedge pclk);
    instr <= i;
    instr_gate_n <= g;
    r_source_sel <= rs;
    {ram_a_addr, ram_b_addr} <= ab;
    ext_r_operand_in <= e;
    b_far <= bf;
    {ram_we_n, y_drive_n, b_drive_n} <= c;
    carry_in <= seed[7];
    y_far <= rnd();
    shift_far <= rnd();
    #1;
  endtask

  task automatic idle();
    go(9'h1ec, 1'b1, 1'b0, 8'h00, rnd(), rnd(), 3'b111);
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    repeat (5000) @(posedge pclk);
    bad_count++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'hb93fbebd;
    bad_count = 0;
    samples_checked = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, ram_a_addr, ram_b_addr, instr, carry_in} = '0;
    {r_source_sel, ext_r_operand_in, bottom_slice_strap, strap_far, y_far, b_far, shift_far} = '0;
    {instr_gate_n, b_drive_n, y_drive_n, ram_we_n} = 4'hf;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rd, {25'h0, Q_RST, SIGN_RST, 2'b10});
    apb(1'b1, PEEK_ADDR_OFS, 32'h5);
    apb(1'b0, PEEK_ADDR_OFS, 32'h0);
    chk(rd, 32'h5);
    apb(1'b0, 8'h0c, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    // External data through the result bus into every word, gate held off
    for (k = 0; k < 16; k++) begin
      go(9'h1ec, 1'b1, 1'b0, {4'h0, k[3:0]}, rnd(), rnd(), 3'b011);
      ram_m[k] = y_far;
      chk(write_or_top_strap, 2'b11);
    end
    // Random bus values while the enable is high must not leak into later reads
    for (k = 0; k < 16; k++) begin
      go(9'h1ec, 1'b1, 1'b0, {k[3:0], 4'(15 - k)}, rnd(), rnd(), 3'b100);
      chk({b_port_bus_oe, b_port_bus_out}, {1'b1, 4'(ram_m[15 - k])});
      f = 4'(ram_m[k] + carry_in);
      chk({y_oe, y_out, zero_in}, {1'b1, f, f == 4'h0});
    end
    for (k = 0; k < 8; k++) begin
      go(9'h1ec, 1'b1, 1'b1, 8'h00, rnd(), rnd(), 3'b101);
      chk({b_port_bus_oe, y_out}, {1'b0, 4'(ext_r_operand_in + carry_in)});
      go(9'h1e9, 1'b1, 1'b0, 8'h00, rnd(), rnd(), 3'b101);
      chk(y_out, 4'(b_far + carry_in));
    end
    go(9'h1f0, 1'b1, 1'b1, 8'h00, rnd(), rnd(), 3'b101);
    chk({y_out, zero_in, gen_or_sign, propagate_or_overflow}, 7'b0000110);
    go(9'h1ec, 1'b1, 1'b1, 8'h09, rnd(), rnd(), 3'b001);
    ram_m[9] = 4'(ext_r_operand_in + carry_in);
    idle();
    apb(1'b1, PEEK_ADDR_OFS, 32'h9);
    apb(1'b0, PEEK_DATA_OFS, 32'h0);
    chk(rd, ram_m[9]);
    // Q load, then hold with a different operand on the bus
    go(9'h0c9, 1'b0, 1'b0, 8'h00, rnd(), rnd(), 3'b101);
    q_m = 4'(b_far + carry_in);
    chk(write_or_top_strap, 2'b01);
    go(9'h0c9, 1'b1, 1'b0, 8'h00, rnd(), 4'(q_m + 5), 3'b101);
    chk(write_or_top_strap, 2'b11);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rd[6:3], q_m);
    go(9'h189, 1'b0, 1'b0, 8'h00, rnd(), rnd(), 3'b101);
    chk(write_or_top_strap, 2'b11);
    go(9'h10c, 1'b1, 1'b1, 8'h00, rnd(), rnd(), 3'b101);
    f = 4'(ext_r_operand_in + carry_in);
    chk({y_out, alu_shift_high, alu_shift_low.oe}, {f[2:0], shift_far[0], f[3], 2'b10});
    go(9'h04c, 1'b1, 1'b1, 8'h00, rnd(), rnd(), 3'b101);
    f = 4'(ext_r_operand_in + carry_in);
    chk({y_out, alu_shift_low, alu_shift_high.oe}, {shift_far[1], f[3:1], f[0], 2'b10});
    go(9'h14c, 1'b0, 1'b1, 8'h00, rnd(), rnd(), 3'b101);
    chk({q_shift_high_port, q_shift_low_port.oe}, {q_m[3], 2'b10});
    q_m = ((q_m << 1) | shift_far[2]) & 15;
    idle();
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rd[6:3], q_m);
    go({SF_INC, 5'h0}, 1'b1, 1'b0, 8'h03, rnd(), rnd(), 3'b101);
    chk(y_out, 4'(ram_m[3] + 1 + carry_in));
    // Middle slice: no forced increment and no write buffer
    @(posedge pclk);
    bottom_slice_strap <= 1'b1;
    strap_far <= 1'b1;
    go({SF_INC, 5'h0}, 1'b1, 1'b0, 8'h03, rnd(), rnd(), 3'b101);
    chk({y_out, write_or_top_strap.oe}, {4'(ram_m[3] + carry_in), 1'b0});
    @(posedge pclk);
    strap_far <= 1'b0;
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rd, {25'h0, q_m[3:0], 1'b0, 2'b01});
    go(9'h1e7, 1'b1, 1'b1, 8'h00, 4'h7, 4'h1, 3'b101);
    chk({gen_or_sign, propagate_or_overflow}, 2'b11);
    go(9'h1e7, 1'b1, 1'b1, 8'h00, 4'h2, 4'h1, 3'b101);
    chk({gen_or_sign, propagate_or_overflow}, 2'b00);
    go({SF_NORM1, 5'h0}, 1'b1, 1'b0, 8'h03, rnd(), rnd(), 3'b101);
    chk(carry_out, q_m[3] ^ q_m[2]);
    go({SF_NORM2, 5'h0}, 1'b1, 1'b0, 8'h03, rnd(), rnd(), 3'b101);
    f = 4'(ram_m[3] + carry_in);
    chk(carry_out, f[3] ^ f[2]);
    go({SF_DIV, 5'h0}, 1'b0, 1'b0, 8'h35, rnd(), rnd(), 3'b101);
    go({SF_DIV, 5'h0}, 1'b1, 1'b0, 8'h35, rnd(), rnd(), 3'b101);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(zero_line, {1'b0, ~rd[2]});
    @(posedge pclk);
    bottom_slice_strap <= 1'b0;
    // Only the defined special codes are issued
    sf_list = '{SF_UMUL, SF_TMUL, SF_INC, SF_SMAG, SF_TMUL_LAST, SF_NORM1, SF_NORM2, SF_DIV, SF_DIV_LAST};
    foreach (sf_list[j]) begin
      go({sf_list[j], 5'h0}, 1'b0, 1'b0, 8'h12, rnd(), rnd(), 3'b101);
      chk(write_or_top_strap, 2'b01);
      go({sf_list[j], 5'h0}, 1'b1, 1'b0, 8'h12, rnd(), rnd(), 3'b101);
      chk(write_or_top_strap, 2'b11);
    end
    idle();
    conclude();
  end
endmodule
`default_nettype wire
